/* File: logic/usr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - break after a whole low frame, pushed once
// - holding-empty set on transfer, cleared by write; in FIFO mode set while FIFO level is zero
// - transmitter empty only when fully idle
// - receive error flag while errored bytes stored
// - modem deltas latch on changes, raise interrupt
// - ring delta on trailing edge only
// - auto CTS halts transmit while CTS deasserted (CTS state low)
// - modem states inverted pins or loopback bits
// - scratch byte, reset to all ones
// - swap maps scratch to mode and level
// - mode bits pick counted FIFO
// - alternate mode reads receive then transmit
// - polarity bit sets direction output sense
// - four bits pick hysteresis from table
// - line interrupt immediate or at holding
// - sampling bit picks 8x or 16x
// - 16-bit divisor sets bit rate
// - divisor access bit maps divisor registers
// - loopback routes modem outputs to inputs
module usr_regs #(
  parameter logic [7:0] IDENT_CODE = 8'h5C, // arbitrary value
  parameter int         ERR_W      = 7
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial side pins
  input  wire logic        rxPin,
  input  wire logic        ctsPinN,
  input  wire logic        dsrPinN,
  input  wire logic        riPinN,
  input  wire logic        cdPinN,
  output logic             dtrPinN,
  output logic             rtsPinN,
  // transmit core
  input  wire logic        fifoEnable,
  input  wire logic        txHoldTaken,
  input  wire logic        txShiftBusy,
  input  wire logic [7:0]  txFifoLevel,
  output logic             txLoad,
  output logic [7:0]       txLoadData,
  output logic             txHalt,
  // receive core
  input  wire logic [7:0]  rxFifoLevel,
  input  wire logic [7:0]  rxHoldData,
  input  wire logic [3:0]  rxStatusLow,
  input  wire logic        rxPushErr,
  input  wire logic        rxPopErr,
  input  wire logic        rxHeadErr,
  output logic             rxBreakPush,
  // timing and flow control
  output logic             sampleTick,
  output logic             bitTick,
  output logic [5:0]       rtsHyst,
  // interrupt requests
  output logic             modemIrq,
  output logic             lineIrq
);
  // ==========================================================
  // register state
  logic [7:0]  ien_q;
  logic [7:0]  lctl_q;
  logic [7:0]  mctl_q;
  logic [7:0]  fctl_q;
  logic [7:0]  efeat_q;
  logic [7:0]  divLow_q;
  logic [7:0]  divHigh_q;
  logic [7:0]  scratch_q;
  logic [7:0]  emsel_q;
  logic [3:0]  delta_q;
  logic [3:0]  delta_d;
  logic        thre_q;
  logic        brkFlag_q;
  logic        altTx_q;
  logic [ERR_W-1:0] errCnt_q;
  logic [31:0] prdata_q;
  logic        txLoad_q;
  logic [7:0]  txData_q;
  logic        rxSyncA_q;
  logic        rxSyncB_q;
  usr_pkg::usr_brk_t brkState_q;
  logic [3:0]  brkCnt_q;
  logic        brkPush_q;

  usr_side_if sd ();

  // ==========================================================
  // apb decode
  wire logic setup   = psel & ~penable;
  wire logic access  = psel & penable;
  wire logic dlab    = lctl_q[usr_pkg::LCTL_DLAB];
  wire logic swap    = fctl_q[usr_pkg::FCTL_SWAP];
  wire logic hitData = paddr == usr_pkg::OFS_DATA;
  wire logic hitIen  = paddr == usr_pkg::OFS_IEN;
  wire logic hitLctl = paddr == usr_pkg::OFS_LCTL;
  wire logic hitMctl = paddr == usr_pkg::OFS_MCTL;
  wire logic hitLst  = paddr == usr_pkg::OFS_LSTAT;
  wire logic hitMst  = paddr == usr_pkg::OFS_MSTAT;
  wire logic hitScr  = paddr == usr_pkg::OFS_SCR;
  wire logic hitFctl = paddr == usr_pkg::OFS_FCTL;
  wire logic hitEft  = paddr == usr_pkg::OFS_EFEAT;
  wire logic hitAny  = hitData | hitIen | hitLctl | hitMctl | hitLst
                     | hitMst | hitScr | hitFctl | hitEft;
  wire logic wrEn    = access & pwrite & pstrb[0] & hitAny;
  wire logic rdEn    = access & ~pwrite & hitAny;
  wire logic [7:0] wb = pwdata[7:0];

  assign pready  = access;
  assign pslverr = access & ~hitAny;
  assign prdata  = prdata_q;

  // divisor registers replace data and enable while the access bit is set
  wire logic wrDivLo = wrEn & hitData & dlab;
  wire logic wrDivHi = wrEn & hitIen & dlab;
  wire logic wrTx    = wrEn & hitData & ~dlab;
  wire logic wrIen   = wrEn & hitIen & ~dlab;
  wire logic wrScr   = wrEn & hitScr & ~swap;
  wire logic wrEms   = wrEn & hitScr & swap;
  wire logic rdLst   = rdEn & hitLst;
  wire logic rdMst   = rdEn & hitMst;
  wire logic rdLvl   = rdEn & hitScr & swap;

  // ==========================================================
  // line status
  wire logic [15:0] divisor = {divHigh_q, divLow_q};
  wire logic thre    = fifoEnable ? (txFifoLevel == usr_pkg::ZERO8) : thre_q;
  wire logic temt    = thre & ~txShiftBusy;
  wire logic errFlag = errCnt_q != '0;
  wire logic [7:0] lineStatus = {errFlag, temt, thre, brkFlag_q, rxStatusLow};
  wire logic [7:0] modemStatus = {sd.state, delta_q};

  // ==========================================================
  // level counter selection
  wire logic [1:0] cntMode = emsel_q[1:0];
  wire logic pickTx = (cntMode == usr_pkg::CNT_TX)
                    | ((cntMode == usr_pkg::CNT_ALT) & altTx_q);
  wire logic [7:0] levelCount = pickTx ? txFifoLevel : rxFifoLevel;
  wire logic identOk = dlab & (divisor == 16'h0000);

  // read mux; the ident shares the divisor high location
  wire logic [7:0] rdData =
      hitData ? (dlab ? divLow_q : rxHoldData) :
      hitIen  ? (identOk ? IDENT_CODE : (dlab ? divHigh_q : ien_q)) :
      hitLctl ? lctl_q :
      hitMctl ? mctl_q :
      hitLst  ? lineStatus :
      hitMst  ? modemStatus :
      hitScr  ? (swap ? levelCount : scratch_q) :
      hitFctl ? fctl_q :
      hitEft  ? efeat_q : usr_pkg::ZERO8;

  // ==========================================================
  // modem side and flow control
  assign sd.divisor  = divisor;
  assign sd.os16     = emsel_q[usr_pkg::EMS_OS16];
  assign sd.loopback = mctl_q[usr_pkg::MCTL_LOOP];
  assign sd.loopBits = {mctl_q[usr_pkg::MCTL_OP2], mctl_q[usr_pkg::MCTL_OP1],
                        mctl_q[usr_pkg::MCTL_DTR], mctl_q[usr_pkg::MCTL_RTS]};
  assign sd.pinsN    = {cdPinN, riPinN, dsrPinN, ctsPinN};

  usr_baud_gen u_baud (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sd       (sd.baud)
  );
  usr_modem_det u_modem (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sd       (sd.modem)
  );

  assign sampleTick = sd.sampleTick;
  assign bitTick    = sd.bitTick;
  // the core finishes its current character before obeying the halt
  assign txHalt  = efeat_q[usr_pkg::EFEAT_ACTS] & ~sd.state[0];
  wire logic rs485 = fctl_q[usr_pkg::FCTL_RS485];
  wire logic rtsInv = emsel_q[usr_pkg::EMS_RTSINV];
  assign rtsPinN = rs485 ? (~temt ~^ rtsInv) : ~mctl_q[usr_pkg::MCTL_RTS];
  assign dtrPinN = ~mctl_q[usr_pkg::MCTL_DTR];
  assign rtsHyst = usr_pkg::HYST_TABLE[{emsel_q[5:4], fctl_q[1:0]}];
  assign modemIrq = ien_q[usr_pkg::IEN_MODEM] & (|delta_q);
  // immediate mode uses the stored-error sum, delayed mode the head byte
  wire logic lineErr = emsel_q[usr_pkg::EMS_LSIMM] ? errFlag : rxHeadErr;
  assign lineIrq = ien_q[usr_pkg::IEN_LINE] & lineErr;
  assign txLoad     = txLoad_q;
  assign txLoadData = txData_q;
  assign rxBreakPush = brkPush_q;

  // only the deltas captured at setup are cleared, so a change in
  // between stays visible (set wins over clear)
  always_comb begin
    delta_d = (delta_q & ~(rdMst ? prdata_q[3:0] : 4'h0)) | sd.change;
  end

  // ==========================================================
  // break detection
  wire logic rxLow = ~rxSyncB_q;
  wire logic [3:0] frameBits = usr_pkg::FRAME_BASE + {2'b00, lctl_q[1:0]}
                             + {3'b000, lctl_q[usr_pkg::LCTL_PAR]}
                             + {3'b000, lctl_q[usr_pkg::LCTL_STOP]};
  // one extra tick since the first bit period starts part way
  wire logic brkDone = sd.bitTick & (brkCnt_q >= frameBits);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      brkState_q <= usr_pkg::BRK_IDLE;
      brkCnt_q   <= 4'h0;
      brkPush_q  <= 1'b0;
    end else begin
      brkPush_q <= 1'b0;
      case (brkState_q)
        usr_pkg::BRK_IDLE: begin
          brkCnt_q <= 4'h0;
          if (rxLow) begin
            brkState_q <= usr_pkg::BRK_CNT;
          end
        end
        usr_pkg::BRK_CNT: begin
          if (!rxLow) begin
            brkState_q <= usr_pkg::BRK_IDLE;
          end else if (brkDone) begin
            brkState_q <= usr_pkg::BRK_HOLD;
            brkPush_q  <= 1'b1;
          end else if (sd.bitTick) begin
            brkCnt_q <= brkCnt_q + 4'h1;
          end
        end
        usr_pkg::BRK_HOLD: begin
          if (!rxLow) begin
            brkState_q <= usr_pkg::BRK_IDLE;
          end
        end
        default: brkState_q <= usr_pkg::BRK_IDLE;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ien_q     <= usr_pkg::ZERO8;
      lctl_q    <= usr_pkg::ZERO8;
      mctl_q    <= usr_pkg::ZERO8;
      fctl_q    <= usr_pkg::ZERO8;
      efeat_q   <= usr_pkg::ZERO8;
      divLow_q  <= usr_pkg::ZERO8;
      divHigh_q <= usr_pkg::ZERO8;
      scratch_q <= usr_pkg::SCR_RST;
      emsel_q   <= usr_pkg::EMS_RST;
    end else begin
      if (wrIen)                 ien_q     <= wb;
      if (wrEn & hitLctl)        lctl_q    <= wb;
      if (wrEn & hitMctl)        mctl_q    <= wb;
      if (wrEn & hitFctl)        fctl_q    <= wb;
      if (wrEn & hitEft)         efeat_q   <= wb;
      if (wrDivLo)               divLow_q  <= wb;
      if (wrDivHi)               divHigh_q <= wb;
      if (wrScr)                 scratch_q <= wb;
      if (wrEms)                 emsel_q   <= wb;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      delta_q   <= 4'h0;
      thre_q    <= 1'b1;
      brkFlag_q <= 1'b0;
      altTx_q   <= 1'b0;
      errCnt_q  <= '0;
    end else begin
      delta_q <= delta_d;
      // hardware set wins over the host write clearing it
      if (txHoldTaken) begin
        thre_q <= 1'b1;
      end else if (wrTx) begin
        thre_q <= 1'b0;
      end
      if (brkDone & (brkState_q == usr_pkg::BRK_CNT)) begin
        brkFlag_q <= 1'b1;
      end else if (rdLst & prdata_q[4]) begin
        brkFlag_q <= 1'b0;
      end
      if (wrEms) begin
        altTx_q <= 1'b0;
      end else if (rdLvl & (cntMode == usr_pkg::CNT_ALT)) begin
        altTx_q <= ~altTx_q;
      end
      if (rxPushErr & ~rxPopErr) begin
        errCnt_q <= errCnt_q + 1'b1;
      end else if (rxPopErr & ~rxPushErr & errFlag) begin
        errCnt_q <= errCnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_q  <= 32'h00000000;
      txLoad_q  <= 1'b0;
      txData_q  <= usr_pkg::ZERO8;
      rxSyncA_q <= 1'b1;
      rxSyncB_q <= 1'b1;
    end else begin
      if (setup & ~pwrite) begin
        prdata_q <= {24'h000000, rdData};
      end
      txLoad_q  <= wrTx;
      if (wrTx) begin
        txData_q <= wb;
      end
      rxSyncA_q <= rxPin;
      rxSyncB_q <= rxSyncA_q;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_break_single: assert property (rxBreakPush |=> (!rxBreakPush) [*8])
    else $error("break pushed twice");
  chk_thre_fifo: assert property (fifoEnable |-> thre == (txFifoLevel == 8'h00))
    else $error("holding empty does not follow fifo");
  chk_thre_load: assert property (wrTx && !txHoldTaken |=> !thre_q)
    else $error("holding empty not cleared by write");
  chk_temt_idle: assert property (lineStatus[6] |-> thre && !txShiftBusy)
    else $error("transmitter empty while busy");
  chk_err_push: assert property (rxPushErr && !rxPopErr |=> lineStatus[7])
    else $error("error flag missed stored error");
  chk_delta_latch: assert property (sd.change[0] |=> delta_q[0] [*1])
    else $error("cts delta not latched");
  chk_ri_trail: assert property ($fell(sd.state[2]) |=> delta_q[2])
    else $error("ring delta missed trailing edge");
  chk_ri_lead: assert property ($rose(sd.state[2]) && !delta_q[2] && !rdMst |=> !delta_q[2])
    else $error("ring delta on leading edge");
  chk_auto_cts: assert property (efeat_q[7] && !sd.state[0] |-> txHalt)
    else $error("auto cts did not halt");
  chk_loop_map: assert property (mctl_q[4] |-> modemStatus[7:4] ==
    {mctl_q[3], mctl_q[2], mctl_q[0], mctl_q[1]})
    else $error("loopback status mismatch");
  chk_swap_hold: assert property (wrEn && hitScr && swap |=> $stable(scratch_q))
    else $error("scratch written under swap");
  chk_alt_order: assert property (wrEms || (rdLvl && cntMode == 2'h3) |=>
    altTx_q == !($past(wrEms) || $past(altTx_q)))
    else $error("alternate read order broken");
  chk_rs485_pol: assert property (fctl_q[3] && !emsel_q[3] && !temt |-> !rtsPinN)
    else $error("direction output sense wrong");
  chk_mstat_clear: assert property (rdMst && prdata_q[0] && !sd.change[0] |=> !delta_q[0])
    else $error("modem delta not cleared by read");

  cov_break: cover property (rxBreakPush);
  cov_alt_read: cover property (rdLvl && cntMode == 2'h3 && altTx_q);
  cov_modem_irq: cover property (modemIrq && rdMst);
  cov_ident: cover property (rdEn && hitIen && identOk);
endmodule
`default_nettype wire

/* File: logic/usr_pkg.sv */
package usr_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_DATA  = 8'h00;
  localparam logic [7:0] OFS_IEN   = 8'h04;
  localparam logic [7:0] OFS_LCTL  = 8'h0C;
  localparam logic [7:0] OFS_MCTL  = 8'h10;
  localparam logic [7:0] OFS_LSTAT = 8'h14;
  localparam logic [7:0] OFS_MSTAT = 8'h18;
  localparam logic [7:0] OFS_SCR   = 8'h1C;
  localparam logic [7:0] OFS_FCTL  = 8'h20;
  localparam logic [7:0] OFS_EFEAT = 8'h24;
  // ==========================================================
  // field positions
  localparam int LCTL_DLAB    = 7;
  localparam int LCTL_PAR     = 3;
  localparam int LCTL_STOP    = 2;
  localparam int MCTL_DTR     = 0;
  localparam int MCTL_RTS     = 1;
  localparam int MCTL_OP1     = 2;
  localparam int MCTL_OP2     = 3;
  localparam int MCTL_LOOP    = 4;
  localparam int IEN_LINE     = 2;
  localparam int IEN_MODEM    = 3;
  localparam int FCTL_RS485   = 3;
  localparam int FCTL_SWAP    = 6;
  localparam int EFEAT_ACTS   = 7;
  localparam int EMS_RTSINV   = 3;
  localparam int EMS_LSIMM    = 6;
  localparam int EMS_OS16     = 7;
  // ==========================================================
  // reset values and constants
  localparam logic [7:0] SCR_RST  = 8'hFF;
  localparam logic [7:0] EMS_RST  = 8'h80;
  localparam logic [7:0] ZERO8    = 8'h00;
  localparam logic [3:0] OS16_LAST = 4'hF;
  localparam logic [3:0] OS8_LAST  = 4'h7;
  localparam logic [3:0] FRAME_BASE = 4'h8;
  localparam logic [1:0] CNT_ALT  = 2'h3;
  localparam logic [1:0] CNT_TX   = 2'h1;
  // hysteresis in characters, index {mode 5:4, fifo control 1:0}
  localparam logic [5:0] HYST_TABLE [16] = '{
    6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
    6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
  typedef enum logic [2:0] {
    BRK_IDLE = 3'b001,
    BRK_CNT  = 3'b010,
    BRK_HOLD = 3'b100
  } usr_brk_t;
endpackage

/* File: logic/usr_side_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface usr_side_if;
  logic [15:0] divisor;
  logic        os16;
  logic        sampleTick;
  logic        bitTick;
  logic        loopback;
  logic [3:0]  loopBits;
  logic [3:0]  pinsN;
  logic [3:0]  state;
  logic [3:0]  change;
  modport core  (output divisor, os16, loopback, loopBits, pinsN,
                 input sampleTick, bitTick, state, change);
  modport baud  (input divisor, os16, output sampleTick, bitTick);
  modport modem (input loopback, loopBits, pinsN, output state, change);
endinterface
`default_nettype wire

/* File: logic/usr_baud_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module usr_baud_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // divisor in, ticks out
  usr_side_if.baud sd
);
  logic [15:0] divCnt_q;
  logic [3:0]  osCnt_q;
  wire logic       divOn  = sd.divisor != 16'h0000;
  wire logic       divHit = divOn && (divCnt_q >= sd.divisor - 16'h0001);
  // 8x sampling shortens the bit to 8 sample ticks
  wire logic [3:0] osLast = sd.os16 ? usr_pkg::OS16_LAST : usr_pkg::OS8_LAST;
  wire logic       osHit  = osCnt_q >= osLast;
  assign sd.sampleTick = divHit;
  assign sd.bitTick    = divHit && osHit;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_q <= 16'h0000;
      osCnt_q  <= 4'h0;
    end else begin
      divCnt_q <= (divHit || !divOn) ? 16'h0000 : divCnt_q + 16'h0001;
      if (divHit) begin
        osCnt_q <= osHit ? 4'h0 : osCnt_q + 4'h1;
      end
    end
  end
  chk_bit_on_sample: assert property (@(posedge core_clk) disable iff (!resetn)
    sd.bitTick |-> sd.sampleTick && sd.divisor != 16'h0000)
    else $error("bit tick without sample tick");
endmodule
`default_nettype wire

/* File: logic/usr_modem_det.sv */
`timescale 1ns/10ps
`default_nettype none
module usr_modem_det (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // pins in, states out
  usr_side_if.modem sd
);
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  logic [3:0] state_q;
  // bit order {cd, ri, dsr, cts}; pins are active low
  wire logic [3:0] stateNow = sd.loopback ? sd.loopBits : ~syncB_q;
  assign sd.state = stateNow;
  // ring delta only on the trailing edge of ringing
  assign sd.change = {stateNow[3] ^ state_q[3],
                      state_q[2] & ~stateNow[2],
                      stateNow[1:0] ^ state_q[1:0]};
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      syncA_q <= 4'hF;
      syncB_q <= 4'hF;
      state_q <= 4'h0;
    end else begin
      syncA_q <= sd.pinsN;
      syncB_q <= syncA_q;
      state_q <= stateNow;
    end
  end
endmodule
`default_nettype wire

/* File: verification/usr_modem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module usr_modem_model (
  // clock
  input  wire logic       core_clk,
  // wanted line states, asserted high: {cd, ri, dsr, cts}
  input  wire logic [3:0] want,
  input  wire logic       brk,
  // lines toward the device
  output logic            ctsPinN,
  output logic            dsrPinN,
  output logic            riPinN,
  output logic            cdPinN,
  output logic            rxPin
);
  // ==========================================
  // line drivers
  // idle lines are released high, like a real modem at power-up
  initial begin
    {cdPinN, riPinN, dsrPinN, ctsPinN, rxPin} = 5'h1F;
  end
  // changes land just after an edge; cts deasserted means stop sending
  always @(posedge core_clk) begin
    {cdPinN, riPinN, dsrPinN, ctsPinN} <= ~want;
    rxPin <= ~brk;
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ==========================================
  // signals
  localparam logic [7:0] IDV = 8'h3A; // arbitrary value
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0]  paddr, txFifoLevel, rxFifoLevel, txLoadData, rdv;
  logic [31:0] pwdata, prdata;
  logic        rxPin, ctsPinN, dsrPinN, riPinN, cdPinN, dtrPinN, rtsPinN;
  logic        fifoEnable, txShiftBusy, txLoad, txHalt, rxHeadErr, rxBreakPush;
  logic        sampleTick, bitTick, modemIrq, lineIrq, brk;
  logic [5:0]  rtsHyst;
  logic [3:0]  want;
  logic [2:0]  ev;
  int          n_fail, compares, cycN;
  int          hy [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};

  usr_regs #(.IDENT_CODE(IDV)) usr_regs_inst (
    .core_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .rxPin, .ctsPinN, .dsrPinN, .riPinN, .cdPinN,
    .dtrPinN, .rtsPinN, .fifoEnable, .txHoldTaken(ev[0]), .txShiftBusy, .txFifoLevel,
    .txLoad, .txLoadData, .txHalt, .rxFifoLevel, .rxHoldData(8'h00),
    .rxStatusLow(4'h0), .rxPushErr(ev[1]), .rxPopErr(ev[2]), .rxHeadErr, .rxBreakPush,
    .sampleTick, .bitTick, .rtsHyst, .modemIrq, .lineIrq);
  usr_modem_model usr_modem_model_inst (
    .core_clk, .want, .brk, .ctsPinN, .dsrPinN, .riPinN, .cdPinN, .rxPin);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // a hang costs at most a fraction of a millisecond
  always @(posedge core_clk) begin
    cycN <= cycN + 1;
    if (cycN == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %0h, want %0h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdv = prdata[7:0];
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one idle edge after a write lets combinational outputs settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    ev <= 3'h1 << k;
    @(posedge core_clk);
    ev <= 3'h0;
  endtask
  task automatic done(input string s);
    $display("test %s finished, %0d compares so far", s, compares);
  endtask
  // intervals measured after a second tick, since a mode change may stretch one
  task automatic per(input int e);
    int n = 0;
    repeat (2) @(posedge core_clk iff bitTick === 1'b1);
    do begin
      @(posedge core_clk);
      n++;
    end while (bitTick !== 1'b1);
    chk(n, e);
    chk(sampleTick, 1'b1);
  endtask
  task automatic summarize();
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_scratch();
    rd(usr_pkg::OFS_SCR);
    chk({dtrPinN, rtsPinN, rdv}, 10'h3FF);
    wr(usr_pkg::OFS_SCR, 8'h5A);
    rd(usr_pkg::OFS_SCR);
    chk(rdv, 8'h5A);
    rd(8'h3C);
    chk({errv, rdv}, 9'h100);
    done("scratch");
  endtask
  task automatic t_modem();
    wr(usr_pkg::OFS_IEN, 8'h08);
    rd(usr_pkg::OFS_MSTAT);
    want <= 4'b0001;
    cyc(6);
    chk(modemIrq, 1'b1);
    rd(usr_pkg::OFS_MSTAT);
    chk(rdv, 8'h11);
    rd(usr_pkg::OFS_MSTAT);
    chk({modemIrq, rdv}, 9'h010);
    want <= 4'b0101;
    cyc(6);
    rd(usr_pkg::OFS_MSTAT);
    chk(rdv, 8'h50);
    want <= 4'b1011;
    cyc(6);
    rd(usr_pkg::OFS_MSTAT);
    chk(rdv, 8'hBE);
    wr(usr_pkg::OFS_MCTL, 8'h15);
    cyc(3);
    rd(usr_pkg::OFS_MSTAT);
    chk(rdv[7:4], 4'h6);
    wr(usr_pkg::OFS_MCTL, 8'h0A);
    chk({dtrPinN, rtsPinN}, 2'b10);
    wr(usr_pkg::OFS_EFEAT, 8'h80);
    want <= 4'b0000;
    cyc(6);
    chk(txHalt, 1'b1);
    want <= 4'b0001;
    cyc(6);
    chk(txHalt, 1'b0);
    done("modem");
  endtask
  task automatic t_swap();
    rxFifoLevel <= 8'h21;
    txFifoLevel <= 8'h12;
    wr(usr_pkg::OFS_FCTL, 8'h40);
    for (int m = 0; m < 3; m++) begin
      wr(usr_pkg::OFS_SCR, 8'h80 | 8'(m));
      rd(usr_pkg::OFS_SCR);
      chk(rdv, (m == 1) ? 8'h12 : 8'h21);
    end
    wr(usr_pkg::OFS_SCR, 8'h83);
    for (int i = 0; i < 5; i++) begin
      rd(usr_pkg::OFS_SCR);
      chk(rdv, i[0] ? 8'h12 : 8'h21);
    end
    for (int c = 0; c < 16; c++) begin
      wr(usr_pkg::OFS_SCR, {2'b10, c[3:2], 4'h0});
      wr(usr_pkg::OFS_FCTL, {6'h10, c[1:0]});
      chk(rtsHyst, hy[c]);
    end
    wr(usr_pkg::OFS_FCTL, 8'h00);
    rd(usr_pkg::OFS_SCR);
    chk(rdv, 8'h5A);
    done("swap");
  endtask
  task automatic t_tx();
    fifoEnable <= 1'b1;
    txFifoLevel <= 8'h00;
    wr(usr_pkg::OFS_FCTL, 8'h48);
    wr(usr_pkg::OFS_SCR, 8'h80);
    cyc(2);
    rd(usr_pkg::OFS_LSTAT);
    chk({rtsPinN, rdv[6:5]}, 3'b111);
    txShiftBusy <= 1'b1;
    cyc(3);
    rd(usr_pkg::OFS_LSTAT);
    chk({rtsPinN, rdv[6:5]}, 3'b001);
    wr(usr_pkg::OFS_SCR, 8'h88);
    txFifoLevel <= 8'h03;
    cyc(3);
    rd(usr_pkg::OFS_LSTAT);
    chk({rtsPinN, rdv[6:5]}, 3'b100);
    txShiftBusy <= 1'b0;
    txFifoLevel <= 8'h00;
    cyc(3);
    chk(rtsPinN, 1'b0);
    wr(usr_pkg::OFS_FCTL, 8'h00);
    fifoEnable <= 1'b0;
    bus(1'b1, usr_pkg::OFS_DATA, 8'hA5);
    @(posedge core_clk);
    chk(txLoad, 1'b1);
    rd(usr_pkg::OFS_LSTAT);
    chk({txLoadData, rdv[5]}, 9'h14A);
    pulse(0);
    cyc(1);
    rd(usr_pkg::OFS_LSTAT);
    chk(rdv[5], 1'b1);
    done("transmit");
  endtask
  task automatic t_err();
    wr(usr_pkg::OFS_IEN, 8'h04);
    rxHeadErr <= 1'b1;
    cyc(2);
    chk(lineIrq, 1'b1);
    rxHeadErr <= 1'b0;
    pulse(1);
    cyc(2);
    rd(usr_pkg::OFS_LSTAT);
    chk({lineIrq, rdv[7]}, 2'b01);
    wr(usr_pkg::OFS_FCTL, 8'h40);
    wr(usr_pkg::OFS_SCR, 8'hC0);
    chk(lineIrq, 1'b1);
    pulse(2);
    cyc(2);
    rd(usr_pkg::OFS_LSTAT);
    chk({lineIrq, rdv[7]}, 2'b00);
    done("error");
  endtask
  task automatic t_baud();
    int n = 0;
    wr(usr_pkg::OFS_LCTL, 8'h80);
    wr(usr_pkg::OFS_DATA, 8'h03);
    wr(usr_pkg::OFS_IEN, 8'h00);
    rd(usr_pkg::OFS_DATA);
    chk(rdv, 8'h03);
    wr(usr_pkg::OFS_SCR, 8'h80);
    per(48);
    wr(usr_pkg::OFS_SCR, 8'h00);
    per(24);
    wr(usr_pkg::OFS_DATA, 8'h00);
    rd(usr_pkg::OFS_IEN);
    chk(rdv, IDV);
    wr(usr_pkg::OFS_SCR, 8'h80);
    wr(usr_pkg::OFS_DATA, 8'h01);
    wr(usr_pkg::OFS_LCTL, 8'h00);
    rd(usr_pkg::OFS_IEN);
    chk(rdv, 8'h04);
    brk <= 1'b1;
    repeat (400) begin
      @(posedge core_clk);
      if (rxBreakPush === 1'b1) n++;
    end
    rd(usr_pkg::OFS_LSTAT);
    chk({n[7:0], rdv[4]}, 9'h003);
    brk <= 1'b0;
    cyc(4);
    rd(usr_pkg::OFS_LSTAT);
    chk(rdv[4], 1'b0);
    done("baud and break");
  endtask
  // ==========================================
  // main sequence
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, fifoEnable, txShiftBusy, rxHeadErr, brk} = '0;
    {paddr, pwdata, txFifoLevel, rxFifoLevel, want, ev} = '0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_scratch();
    t_modem();
    t_swap();
    t_tx();
    t_err();
    t_baud();
    summarize();
  end
endmodule
`default_nettype wire
